// ==== verilog/fault_gating_pkg.sv ====
// constants shared by the gate-driver fault supervision block
package fault_gating_pkg;
	localparam int CLK_MHZ          = 200;
	localparam int FRAME_GAP_NS     = 19000;
	localparam int FRAME_GAP_CYCLES = (FRAME_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int FRAME_BITS       = 24;
	localparam int CRC_BITS         = 8;
	localparam logic [7:0] CRC_POLY = 8'h2F;
	localparam logic [7:0] CRC_INIT = 8'hFF;
	localparam int DEADTIME_W       = 8;
	localparam int MONITOR_W        = 8;
	localparam int FILTER_W         = 8;
	localparam int THRESH_W         = 8;
	localparam logic [7:0] DEADTIME_RESET = 8'h10;
	localparam logic [7:0] MONITOR_RESET  = 8'h20;
	localparam logic [7:0] FILTER_RESET   = 8'h04;
	localparam logic [7:0] THRESH_RESET   = 8'h80;
	// index of each flag inside the clear vector and the status outputs
	localparam int FLAG_GATE     = 0;
	localparam int FLAG_SHORT    = 1;
	localparam int FLAG_OVERCUR  = 2;
	localparam int FLAG_DEADTIME = 3;
	localparam int FLAG_WATCHDOG = 4;
	localparam int FLAG_SERIAL   = 5;
	localparam int FLAG_REGUV    = 6;
	localparam int FLAG_COUNT    = 7;
	typedef enum logic [1:0]
	{
		FRAME_IDLE = 2'b00,
		FRAME_BUSY = 2'b01,
		FRAME_GAP  = 2'b11
	} frame_state_type;
endpackage

// ==== verilog/gate_driver_fault_gating.sv ====
// fault supervision, serial frame checking and pwm gating of a gate driver
// Operation
// - low fail-safe enable blocks pwm output
// - unlock bit set keeps pwm disabled
// - delayed gate-voltage fault latches, locks pwm
// - gate-voltage mask zero stops pwm lockout
// - short-circuit latches, blocks pwm, never masked
// - short-circuit threshold and filter are settable
// - dead time enforced; violation sets fault flag
// - dead time programmable; dead-time fault maskable
// - overcurrent latches unmasked, pwm keeps running
// - overcurrent threshold and filter are settable
// - die watchdog failure at start sets flag
// - frames must be multiples of 24 clocks
// - bad frame crc sets serial error
// - frame gap under 19 us flags error
// - undriven bus at start may flag error
// - self test also clears serial error
// - regulator undervoltage latches until host clears
// - settings need unlock; clears always allowed
`timescale 1ns/1ps
module gate_driver_fault_gating #(
	parameter int GAP_CYCLES = fault_gating_pkg::FRAME_GAP_CYCLES
) (
	input  wire logic                 CLK_IN,
	input  wire logic                 RESET_N_IN,
	input  wire logic                 FAILSAFE_ENABLE_N_IN,
	input  wire logic                 PWM_HIGH_IN,
	input  wire logic                 PWM_LOW_IN,
	input  wire logic                 GATE_MONITOR_BAD_IN,
	input  wire logic [7:0]           SHORT_SENSE_IN,
	input  wire logic [7:0]           CURRENT_SENSE_IN,
	input  wire logic                 DIE_LINK_FAIL_IN,
	input  wire logic                 REG_UNDERVOLT_IN,
	input  wire logic                 CHIP_SELECT_N_IN,
	input  wire logic                 SERIAL_CLOCK_IN,
	input  wire logic                 SERIAL_DATA_IN,
	input  wire logic                 SELF_TEST_CLEAR_IN,
	input  wire logic                 CONFIG_UNLOCK_WRITE_IN,
	input  wire logic                 CONFIG_UNLOCK_VALUE_IN,
	input  wire logic                 SETTINGS_WRITE_IN,
	input  wire logic [7:0]           DEADTIME_SETTINGS_IN,
	input  wire logic [7:0]           GATE_MONITOR_SETTINGS_IN,
	input  wire logic [7:0]           SHORT_THRESHOLD_IN,
	input  wire logic [7:0]           SHORT_FILTER_IN,
	input  wire logic [7:0]           OVERCURRENT_THRESHOLD_IN,
	input  wire logic [7:0]           OVERCURRENT_FILTER_IN,
	input  wire logic                 GATE_VOLTAGE_FAULT_MASK_IN,
	input  wire logic                 DEADTIME_FAULT_MASK_IN,
	input  wire logic [6:0]           FLAG_CLEAR_IN,
	output logic                      GATE_HIGH_OUT,
	output logic                      GATE_LOW_OUT,
	output logic                      CONFIG_UNLOCK_OUT,
	output logic [6:0]                FAULT_FLAGS_OUT
);
	localparam int NF = fault_gating_pkg::FLAG_COUNT;

	// synchronisers for the nine single-bit pins from outside the clock domain; the sense buses are used unsynchronised
	localparam int NS = 9;
	logic [NS-1:0] raw_pins;
	logic [NS-1:0] sync1_q;
	logic [NS-1:0] sync2_q;
	assign raw_pins = {FAILSAFE_ENABLE_N_IN, PWM_HIGH_IN, PWM_LOW_IN, GATE_MONITOR_BAD_IN, DIE_LINK_FAIL_IN,
		REG_UNDERVOLT_IN, CHIP_SELECT_N_IN, SERIAL_CLOCK_IN, SERIAL_DATA_IN};
	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			sync1_q <= {1'b0, 5'h00, 1'b1, 2'h0};
			sync2_q <= {1'b0, 5'h00, 1'b1, 2'h0};
		end
		else
		begin
			sync1_q <= raw_pins;
			sync2_q <= sync1_q;
		end
	end
	logic fsen_n, pwm_h, pwm_l, gmon_bad, die_fail, reg_uv, cs_n, sclk, sdata;
	assign fsen_n   = sync2_q[8];
	assign pwm_h    = sync2_q[7];
	assign pwm_l    = sync2_q[6];
	assign gmon_bad = sync2_q[5];
	assign die_fail = sync2_q[4];
	assign reg_uv   = sync2_q[3];
	assign cs_n     = sync2_q[2];
	assign sclk     = sync2_q[1];
	assign sdata    = sync2_q[0];

	// configuration, only taken while unlocked
	logic       unlock_q;
	logic [7:0] deadtime_q, monitor_q, sc_thr_q, sc_filt_q, oc_thr_q, oc_filt_q;
	logic       gmask_q, dmask_q;
	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
			unlock_q <= 1'b0;
		else if (CONFIG_UNLOCK_WRITE_IN)
			unlock_q <= CONFIG_UNLOCK_VALUE_IN;
	end
	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			deadtime_q <= fault_gating_pkg::DEADTIME_RESET;
			monitor_q  <= fault_gating_pkg::MONITOR_RESET;
			sc_thr_q   <= fault_gating_pkg::THRESH_RESET;
			sc_filt_q  <= fault_gating_pkg::FILTER_RESET;
			oc_thr_q   <= fault_gating_pkg::THRESH_RESET;
			oc_filt_q  <= fault_gating_pkg::FILTER_RESET;
			gmask_q    <= 1'b1;
			dmask_q    <= 1'b1;
		end
		else if (SETTINGS_WRITE_IN && unlock_q)
		begin
			deadtime_q <= DEADTIME_SETTINGS_IN;
			monitor_q  <= GATE_MONITOR_SETTINGS_IN;
			sc_thr_q   <= SHORT_THRESHOLD_IN;
			sc_filt_q  <= SHORT_FILTER_IN;
			oc_thr_q   <= OVERCURRENT_THRESHOLD_IN;
			oc_filt_q  <= OVERCURRENT_FILTER_IN;
			gmask_q    <= GATE_VOLTAGE_FAULT_MASK_IN;
			dmask_q    <= DEADTIME_FAULT_MASK_IN;
		end
	end

	// detection filters: condition must persist for the programmed cycles
	logic [7:0] gmon_cnt_q, sc_cnt_q, oc_cnt_q;
	logic       gate_evt, sc_evt, oc_evt;
	assign gate_evt = gmon_bad && (gmon_cnt_q >= monitor_q);
	assign sc_evt   = (SHORT_SENSE_IN >= sc_thr_q) && (sc_cnt_q >= sc_filt_q);
	assign oc_evt   = (CURRENT_SENSE_IN >= oc_thr_q) && (oc_cnt_q >= oc_filt_q);
	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			gmon_cnt_q <= 8'h00;
			sc_cnt_q   <= 8'h00;
			oc_cnt_q   <= 8'h00;
		end
		else
		begin
			gmon_cnt_q <= !gmon_bad ? 8'h00 : (gate_evt ? gmon_cnt_q : gmon_cnt_q + 8'h01);
			sc_cnt_q   <= (SHORT_SENSE_IN < sc_thr_q) ? 8'h00 : (sc_evt ? sc_cnt_q : sc_cnt_q + 8'h01);
			oc_cnt_q   <= (CURRENT_SENSE_IN < oc_thr_q) ? 8'h00 : (oc_evt ? oc_cnt_q : oc_cnt_q + 8'h01);
		end
	end

	// dead time: each side turns on only after both were off for the set time
	logic [7:0] off_cnt_q;
	logic       dt_viol, dt_ready, block;
	assign dt_ready = off_cnt_q >= deadtime_q;
	// a one-sided request held back by a block is not a dead-time fault
	assign dt_viol  = (pwm_h && pwm_l)
		|| (!block && (pwm_h || pwm_l) && !GATE_HIGH_OUT && !GATE_LOW_OUT && !dt_ready);
	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
			off_cnt_q <= 8'h00;
		else if (GATE_HIGH_OUT || GATE_LOW_OUT)
			off_cnt_q <= 8'h00;
		else if (!dt_ready)
			off_cnt_q <= off_cnt_q + 8'h01;
	end

	// serial frame checker: bit count, crc and inter-frame gap
	fault_gating_pkg::frame_state_type frame_q;
	logic        sclk_d_q;
	logic [7:0]  bit_cnt_q;
	logic [7:0]  crc_q;
	logic [15:0] gap_cnt_q;
	logic        frame_err, sclk_rise, cs_fall;
	logic [7:0]  crc_next;
	assign sclk_rise = sclk && !sclk_d_q;
	assign crc_next  = {crc_q[6:0], 1'b0} ^ ((crc_q[7] ^ sdata) ? fault_gating_pkg::CRC_POLY : 8'h00);
	assign cs_fall   = !cs_n && frame_q != fault_gating_pkg::FRAME_BUSY;
	// a frame ends good only with bit count a multiple of 24 and zero crc residue
	assign frame_err = (frame_q == fault_gating_pkg::FRAME_BUSY && cs_n
		&& (bit_cnt_q != 8'd0 || crc_q != 8'h00))
		|| (cs_fall && frame_q == fault_gating_pkg::FRAME_GAP);
	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			frame_q   <= fault_gating_pkg::FRAME_IDLE;
			sclk_d_q  <= 1'b0;
			bit_cnt_q <= 8'h00;
			crc_q     <= fault_gating_pkg::CRC_INIT;
			gap_cnt_q <= 16'h0000;
		end
		else
		begin
			sclk_d_q <= sclk;
			case (frame_q)
				fault_gating_pkg::FRAME_IDLE, fault_gating_pkg::FRAME_GAP:
				begin
					gap_cnt_q <= gap_cnt_q + 16'h0001;
					if (gap_cnt_q >= 16'(GAP_CYCLES - 1))
						frame_q <= fault_gating_pkg::FRAME_IDLE;
					if (!cs_n)
					begin
						frame_q   <= fault_gating_pkg::FRAME_BUSY;
						bit_cnt_q <= 8'h00;
						crc_q     <= fault_gating_pkg::CRC_INIT;
					end
				end
				fault_gating_pkg::FRAME_BUSY:
				begin
					if (cs_n)
					begin
						frame_q   <= fault_gating_pkg::FRAME_GAP;
						gap_cnt_q <= 16'h0000;
					end
					else if (sclk_rise)
					begin
						// bit count wraps per 24-bit word; crc runs across the whole frame
						bit_cnt_q <= (bit_cnt_q == 8'(fault_gating_pkg::FRAME_BITS - 1)) ? 8'h00
							: bit_cnt_q + 8'h01;
						crc_q     <= crc_next;
					end
				end
				default:
					frame_q <= fault_gating_pkg::FRAME_IDLE;
			endcase
		end
	end

	// sticky flags; a new event beats a clear in the same cycle
	logic [NF-1:0] flags_q;
	logic [NF-1:0] evt;
	logic [NF-1:0] clr;
	assign evt[fault_gating_pkg::FLAG_GATE]     = gate_evt;
	assign evt[fault_gating_pkg::FLAG_SHORT]    = sc_evt;
	assign evt[fault_gating_pkg::FLAG_OVERCUR]  = oc_evt;
	assign evt[fault_gating_pkg::FLAG_DEADTIME] = dt_viol;
	assign evt[fault_gating_pkg::FLAG_WATCHDOG] = die_fail;
	assign evt[fault_gating_pkg::FLAG_SERIAL]   = frame_err; // undriven select reads as a bad frame
	assign evt[fault_gating_pkg::FLAG_REGUV]    = reg_uv;
	always_comb
	begin
		clr = FLAG_CLEAR_IN;
		clr[fault_gating_pkg::FLAG_SERIAL] = FLAG_CLEAR_IN[fault_gating_pkg::FLAG_SERIAL] | SELF_TEST_CLEAR_IN;
	end
	genvar gi;
	generate
		for (gi = 0; gi < NF; gi++)
		begin : g_flag
			always_ff @(posedge CLK_IN or negedge RESET_N_IN)
			begin
				if (!RESET_N_IN)
					flags_q[gi] <= 1'b0;
				else if (evt[gi])
					flags_q[gi] <= 1'b1;
				else if (clr[gi])
					flags_q[gi] <= 1'b0;
			end
		end
	endgenerate

	// output gating
	assign block = fsen_n == 1'b0
		|| unlock_q
		|| (flags_q[fault_gating_pkg::FLAG_GATE] && gmask_q)
		|| flags_q[fault_gating_pkg::FLAG_SHORT];
	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
		begin
			GATE_HIGH_OUT <= 1'b0;
			GATE_LOW_OUT  <= 1'b0;
		end
		else
		begin
			// corrected output: never both on, and only after dead time
			GATE_HIGH_OUT <= !block && pwm_h && !pwm_l && (GATE_HIGH_OUT || dt_ready);
			GATE_LOW_OUT  <= !block && pwm_l && !pwm_h && (GATE_LOW_OUT || dt_ready);
		end
	end
	assign CONFIG_UNLOCK_OUT = unlock_q;
	// dead-time flag shows masked off when its mask bit is zero
	logic [NF-1:0] shown;
	always_comb
	begin
		shown = flags_q;
		shown[fault_gating_pkg::FLAG_DEADTIME] = flags_q[fault_gating_pkg::FLAG_DEADTIME] & dmask_q;
	end
	always_ff @(posedge CLK_IN or negedge RESET_N_IN)
	begin
		if (!RESET_N_IN)
			FAULT_FLAGS_OUT <= 7'h00;
		else
			FAULT_FLAGS_OUT <= shown;
	end

	a_failsafe_block: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		!fsen_n |=> !GATE_HIGH_OUT && !GATE_LOW_OUT) else $error("pwm passed with failsafe low");
	a_unlock_block: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		unlock_q |=> !GATE_HIGH_OUT && !GATE_LOW_OUT) else $error("pwm passed while unlocked");
	a_short_block: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		flags_q[fault_gating_pkg::FLAG_SHORT] |=> !GATE_HIGH_OUT && !GATE_LOW_OUT) else $error("pwm during short");
	a_gate_lock: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		flags_q[fault_gating_pkg::FLAG_GATE] && gmask_q |=> !GATE_HIGH_OUT) else $error("pwm during gate fault");
	a_no_overlap: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		!(GATE_HIGH_OUT && GATE_LOW_OUT)) else $error("both gates on");
	a_flag_sticky: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		flags_q[fault_gating_pkg::FLAG_OVERCUR] && !clr[fault_gating_pkg::FLAG_OVERCUR]
		|=> flags_q[fault_gating_pkg::FLAG_OVERCUR]) else $error("flag lost without clear");
	a_serial_set: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		frame_err |=> flags_q[fault_gating_pkg::FLAG_SERIAL]) else $error("serial error not flagged");
	a_locked_cfg: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		!unlock_q |=> $stable(deadtime_q) && $stable(gmask_q)) else $error("settings changed while locked");
endmodule

// ==== verification/host_spi_model.sv ====
// host serial master model driving the frame pins of the fault gating block
`timescale 1ns/1ps
module host_spi_model (
	output logic CS_N_OUT,
	output logic SCLK_OUT,
	output logic SDATA_OUT
);
	initial
	begin
		CS_N_OUT = 1'b1;
		SCLK_OUT = 1'b0;
		SDATA_OUT = 1'b0;
	end
	// mode 0, 64 ns clock; clock stands still between frames
	task automatic send(input int n, input logic [47:0] w);
		CS_N_OUT <= 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			SDATA_OUT <= w[i];
			#32 SCLK_OUT <= 1'b1;
			#32 SCLK_OUT <= 1'b0;
		end
		#32 CS_N_OUT <= 1'b1;
		// released line must not look like held data
		SDATA_OUT <= ~SDATA_OUT;
	endtask
endmodule

// ==== verification/gate_driver_fault_gating_test.sv ====
// self-checking bench for the gate driver fault gating block
`timescale 1ns/1ps
`define CHECK(got, exp) \
	begin \
		n_compared++; \
		if ((got) !== (exp)) \
		begin \
			failures++; \
			$display("Error at %0t: got %h expected %h", $time, got, exp); \
		end \
	end
module gate_driver_fault_gating_test;
	logic       clk, rst_n, fs_n, pwm_h, pwm_l, mon_bad, link_fail, reg_uv;
	logic       st_clr, un_wr, un_val, set_wr, gv_mask, dt_mask, gh, gl, unlock;
	logic [7:0] short_s, cur_s, sc_th, oc_th, mon_set, dt_set;
	logic [6:0] clr, flags;
	logic [23:0] w;
	wire        cs_n, sclk, sdata;
	int         failures = 0;
	int         n_compared = 0;
	host_spi_model i_host (.CS_N_OUT(cs_n), .SCLK_OUT(sclk), .SDATA_OUT(sdata));
	gate_driver_fault_gating #(.GAP_CYCLES(20)) i_dut (
		.CLK_IN(clk), .RESET_N_IN(rst_n), .FAILSAFE_ENABLE_N_IN(fs_n),
		.PWM_HIGH_IN(pwm_h), .PWM_LOW_IN(pwm_l), .GATE_MONITOR_BAD_IN(mon_bad),
		.SHORT_SENSE_IN(short_s), .CURRENT_SENSE_IN(cur_s), .DIE_LINK_FAIL_IN(link_fail),
		.REG_UNDERVOLT_IN(reg_uv), .CHIP_SELECT_N_IN(cs_n), .SERIAL_CLOCK_IN(sclk),
		.SERIAL_DATA_IN(sdata), .SELF_TEST_CLEAR_IN(st_clr), .CONFIG_UNLOCK_WRITE_IN(un_wr),
		.CONFIG_UNLOCK_VALUE_IN(un_val), .SETTINGS_WRITE_IN(set_wr), .DEADTIME_SETTINGS_IN(dt_set),
		.GATE_MONITOR_SETTINGS_IN(mon_set), .SHORT_THRESHOLD_IN(sc_th), .SHORT_FILTER_IN(8'h04),
		.OVERCURRENT_THRESHOLD_IN(oc_th), .OVERCURRENT_FILTER_IN(8'h04),
		.GATE_VOLTAGE_FAULT_MASK_IN(gv_mask), .DEADTIME_FAULT_MASK_IN(dt_mask), .FLAG_CLEAR_IN(clr),
		.GATE_HIGH_OUT(gh), .GATE_LOW_OUT(gl), .CONFIG_UNLOCK_OUT(unlock), .FAULT_FLAGS_OUT(flags));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic tally_and_finish;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wait_flag(input int b);
		int k;
		k = 0;
		while (flags[b] !== 1'b1 && k < 300)
		begin
			tick(1);
			k++;
		end
		if (flags[b] !== 1'b1)
		begin
			failures++;
			tally_and_finish();
		end
	endtask
	task automatic clear_all;
		clr <= 7'h7F;
		tick(1);
		clr <= 7'h00;
		tick(3);
	endtask
	task automatic set_unlock(input logic v);
		un_val <= v;
		un_wr <= 1'b1;
		tick(1);
		un_wr <= 1'b0;
		tick(30);
	endtask
	task automatic write_settings;
		set_wr <= 1'b1;
		tick(1);
		set_wr <= 1'b0;
		tick(3);
	endtask
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] c;
		c = fault_gating_pkg::CRC_INIT;
		for (int i = 15; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? fault_gating_pkg::CRC_POLY : 8'h00);
		return c;
	endfunction
	task automatic t_failsafe_unlock;
		`CHECK(flags, 7'h00)
		pwm_h <= 1'b1;
		tick(30);
		`CHECK(gh, 1'b0)
		fs_n <= 1'b1;
		tick(30);
		`CHECK(gh, 1'b1)
		set_unlock(1'b1);
		`CHECK({unlock, gh}, 2'b10)
		set_unlock(1'b0);
		`CHECK(gh, 1'b1)
		$display("failsafe and unlock test done");
	endtask
	task automatic t_gate;
		gv_mask <= 1'b0;
		write_settings(); // locked, so ignored
		mon_bad <= 1'b1;
		tick(20);
		`CHECK(flags[0], 1'b0)
		wait_flag(0);
		tick(2);
		`CHECK(gh, 1'b0)
		mon_bad <= 1'b0;
		tick(40);
		`CHECK({flags[0], gh}, 2'b10)
		clear_all();
		tick(30);
		`CHECK(gh, 1'b1)
		set_unlock(1'b1);
		{sc_th, oc_th, mon_set} <= {8'h40, 8'h40, 8'h08};
		write_settings();
		set_unlock(1'b0);
		mon_bad <= 1'b1;
		tick(40);
		`CHECK(gh, 1'b1)
		mon_bad <= 1'b0;
		tick(5);
		clear_all();
		`CHECK(flags[0], 1'b0)
		$display("gate voltage test done");
	endtask
	task automatic t_short_over;
		short_s <= 8'h3F;
		cur_s <= 8'h3F;
		tick(20);
		`CHECK(flags[2:1], 2'b00)
		cur_s <= 8'h40;
		wait_flag(2);
		tick(2);
		`CHECK(gh, 1'b1)
		short_s <= 8'h40;
		wait_flag(1);
		short_s <= 8'h00;
		cur_s <= 8'h00;
		tick(10);
		`CHECK({flags[2:1], gh}, 3'b110)
		clear_all();
		tick(30);
		`CHECK({flags[2:1], gh}, 3'b001)
		$display("short circuit and overcurrent test done");
	endtask
	task automatic t_dead_misc;
		pwm_l <= 1'b1;
		wait_flag(3);
		`CHECK(gh & gl, 1'b0)
		set_unlock(1'b1);
		dt_mask <= 1'b0;
		write_settings();
		set_unlock(1'b0);
		clear_all();
		tick(10);
		`CHECK(flags[3], 1'b0)
		pwm_l <= 1'b0;
		set_unlock(1'b1);
		{dt_mask, dt_set} <= {1'b1, 8'h30};
		write_settings();
		set_unlock(1'b0);
		tick(20);
		clear_all();
		`CHECK({gh, flags[3]}, 2'b10)
		{pwm_h, pwm_l} <= 2'b01;
		tick(30);
		`CHECK({gl, flags[3]}, 2'b01)
		tick(30);
		`CHECK({gh, gl}, 2'b01)
		link_fail <= 1'b1;
		reg_uv <= 1'b1;
		wait_flag(4);
		wait_flag(6);
		{link_fail, reg_uv} <= 2'b00;
		tick(20);
		`CHECK(flags & 7'h50, 7'h50)
		clear_all();
		`CHECK(flags & 7'h50, 7'h00)
		$display("dead time and start-up flag test done");
	endtask
	task automatic t_serial;
		w = {16'hA5C3, crc8(16'hA5C3)};
		i_host.send(24, w);
		tick(40);
		`CHECK(flags[5], 1'b0)
		i_host.send(23, w >> 1);
		tick(10);
		`CHECK(flags[5], 1'b1)
		st_clr <= 1'b1;
		tick(1);
		st_clr <= 1'b0;
		tick(40);
		`CHECK(flags[5], 1'b0)
		i_host.send(24, w ^ 24'h00_0001);
		tick(10);
		`CHECK(flags[5], 1'b1)
		clear_all();
		tick(40);
		i_host.send(24, w);
		#25 i_host.send(24, w);
		tick(10);
		`CHECK(flags[5], 1'b1)
		$display("serial frame test done");
	endtask
	initial
	begin
		{rst_n, fs_n, pwm_h, pwm_l, mon_bad, link_fail, reg_uv, st_clr} = 8'h00;
		{un_wr, un_val, set_wr, gv_mask, dt_mask} = 5'b00011;
		{short_s, cur_s, sc_th, oc_th, mon_set, dt_set} = {16'h0000, 16'h8080, 16'h2010};
		clr = 7'h00;
		tick(12);
		rst_n <= 1'b1;
		tick(2);
		t_failsafe_unlock();
		t_gate();
		t_short_over();
		t_dead_misc();
		t_serial();
		tally_and_finish();
	end
endmodule
